// [mdd_pkg.sv]
// constants for the motion detect data register block.
// assumes one 100 MHz clock and a serial-port decoder that delivers byte accesses.
package mdd_pkg;
  // clock
  localparam int CLK_HZ = 100_000_000;

  // widths
  localparam int DATA_W = 12;
  localparam int THR_W = 11;
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int ACT_COUNT_W = 8;
  localparam int INACT_COUNT_W = 16;
  localparam int SIGN_COPY_W = 4;

  // register offsets
  localparam logic [7:0] STATUS_ADDR = 8'h0b;
  localparam logic [7:0] Y_LOW_ADDR = 8'h10;
  localparam logic [7:0] Y_HIGH_ADDR = 8'h11;
  localparam logic [7:0] Z_LOW_ADDR = 8'h12;
  localparam logic [7:0] Z_HIGH_ADDR = 8'h13;
  localparam logic [7:0] TEMP_LOW_ADDR = 8'h14;
  localparam logic [7:0] TEMP_HIGH_ADDR = 8'h15;
  localparam logic [7:0] AUX_LOW_ADDR = 8'h16;
  localparam logic [7:0] AUX_HIGH_ADDR = 8'h17;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h1f;
  localparam logic [7:0] ACT_THR_LOW_ADDR = 8'h20;
  localparam logic [7:0] ACT_THR_HIGH_ADDR = 8'h21;
  localparam logic [7:0] ACT_TIME_ADDR = 8'h22;
  localparam logic [7:0] INACT_THR_LOW_ADDR = 8'h23;
  localparam logic [7:0] INACT_THR_HIGH_ADDR = 8'h24;
  localparam logic [7:0] INACT_TIME_LOW_ADDR = 8'h25;
  localparam logic [7:0] INACT_TIME_HIGH_ADDR = 8'h26;

  // field positions
  localparam int MOTION_FLAG_BIT = 4;
  localparam int STILL_FLAG_BIT = 5;
  localparam int THR_HIGH_MSB = 2;

  // values
  localparam logic [7:0] SOFT_RESET_CODE = 8'h52;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] ACT_TIME_SINGLE = 8'h01;
endpackage

// [mdd_run_counter.sv]
// consecutive-sample run counter used by activity and inactivity detection.
// assumes strobe is a one-cycle pulse per output sample and clear wins over it.
`timescale 1ns/10ps
module mdd_run_counter #(
  parameter int CountW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sample side
  input wire logic clear,
  input wire logic strobe,
  input wire logic qualify,
  input wire logic [CountW-1:0] target,
  // event
  output logic hit
);
  typedef struct packed {
    logic [CountW-1:0] count;
  } mdd_cnt_state_t;

  mdd_cnt_state_t st_r;
  mdd_cnt_state_t st_nxt;
  logic [CountW-1:0] effTarget;
  logic [CountW:0] countPlusOne;

  // zero behaves as one so a single qualifying sample is enough
  assign effTarget = (target == '0) ? CountW'(1) : target;
  assign countPlusOne = {1'b0, st_r.count} + (CountW+1)'(1);

  always_comb begin
    st_nxt = st_r;
    hit = 1'b0;
    if (clear) begin
      st_nxt.count = '0;
    end else if (strobe) begin
      if (qualify) begin
        hit = (countPlusOne >= {1'b0, effTarget});
        // saturate so a long run never wraps back to a false restart
        if (st_r.count < effTarget) begin
          st_nxt.count = countPlusOne[CountW-1:0];
        end
      end else begin
        st_nxt.count = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  run_restart_a: assert property (@(posedge clk) disable iff (rst)
    (strobe && !qualify) |=> (st_r.count == '0))
    else $error("run count did not restart after a failing sample");

  zero_target_a: assert property (@(posedge clk) disable iff (rst)
    (strobe && qualify && !clear && (target == '0)) |-> hit)
    else $error("zero target did not act as one");

  run_length_a: assert property (@(posedge clk) disable iff (rst)
    (strobe && qualify && !clear && (target > CountW'(1)) && (st_r.count == '0)) |-> !hit)
    else $error("event fired before the programmed run length");
endmodule

// [mdd_regs.sv]
// result, soft-reset and motion threshold/timer registers of the sensor.
// assumes the serial-port decoder presents one byte access per enable pulse and
// that the output sample strobe and sample words arrive synchronous to clk.
`timescale 1ns/10ps
// Summary of operation
// - y result is 12-bit signed, low byte at 0x10, top nibble at 0x11.
// - z result is 12-bit signed, low byte at 0x12, top nibble at 0x13.
// - temperature result is 12-bit signed, low byte 0x14, top nibble 0x15.
// - auxiliary converter result 12-bit signed, low byte 0x16, top nibble 0x17.
// - high result bytes copy bit 11 into bits 15 to 12.
// - writing 0x52 to 0x1f resets at once, clears settings, enters standby.
// - after soft reset interrupt pins float, held by external keepers.
// - soft-reset register is write-only and always reads zero.
// - activity compares each sample magnitude with the 11-bit activity threshold.
// - activity threshold is low byte plus bits 10:8 from high register.
// - activity needs the programmed count of consecutive over-threshold samples.
// - activity time zero acts as one.
// - wake-up mode ignores activity time, one sample suffices.
// - inactivity compares magnitudes with an 11-bit threshold, low byte plus three bits.
// - inactivity needs the 16-bit count of consecutive all-below samples.
// - inactivity count low byte at 0x25, high byte at 0x26.
// - inactivity time zero acts as one.
// - thresholds are raw codes; host scales by range factor.
// - detected activity sets status bit 4 for the host.
module mdd_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial decoder
  input wire logic [mdd_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [mdd_pkg::BYTE_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [mdd_pkg::BYTE_W-1:0] regRdData,
  // samples from the converter
  input wire logic sampleStrobe,
  input wire logic [mdd_pkg::DATA_W-1:0] xAccel,
  input wire logic [mdd_pkg::DATA_W-1:0] yAccel,
  input wire logic [mdd_pkg::DATA_W-1:0] zAccel,
  input wire logic [mdd_pkg::DATA_W-1:0] tempData,
  input wire logic [mdd_pkg::DATA_W-1:0] auxData,
  // mode inputs from the power control logic
  input wire logic wakeUpMode,
  input wire logic measureEnable,
  input wire logic intArm,
  // status
  output logic motionFlag,
  output logic stillFlag,
  output logic standby,
  output logic softResetPulse,
  // interrupt pin
  output logic intOut,
  output logic intOe
);
  import mdd_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] y;
    logic [DATA_W-1:0] z;
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] aux;
    logic [BYTE_W-1:0] actThrLow;
    logic [BYTE_W-1:0] actThrHigh;
    logic [BYTE_W-1:0] actTime;
    logic [BYTE_W-1:0] inactThrLow;
    logic [BYTE_W-1:0] inactThrHigh;
    logic [BYTE_W-1:0] inactTimeLow;
    logic [BYTE_W-1:0] inactTimeHigh;
    logic motion;
    logic still;
    logic standby;
    logic intOe;
    logic softPulse;
    logic [BYTE_W-1:0] rdData;
  } mdd_state_t;

  localparam mdd_state_t RESET_STATE = '{standby: 1'b1, default: '0};

  mdd_state_t st_r;
  mdd_state_t st_nxt;

  logic softHit;
  logic statusRead;
  logic sampleTake;
  logic [THR_W-1:0] actThr;
  logic [THR_W-1:0] inactThr;
  logic [DATA_W-1:0] xMag;
  logic [DATA_W-1:0] yMag;
  logic [DATA_W-1:0] zMag;
  logic actQualify;
  logic inactQualify;
  logic [ACT_COUNT_W-1:0] actTarget;
  logic [INACT_COUNT_W-1:0] inactTarget;
  logic actHit;
  logic inactHit;

  // magnitude of a two's-complement code; -2048 maps to 2048, still fits 12 bits
  function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] m;
    m = v[DATA_W-1] ? DATA_W'(~v + DATA_W'(1)) : v;
    return m;
  endfunction

  // high result byte: sign copies above the top nibble
  function automatic logic [BYTE_W-1:0] highByte(input logic [DATA_W-1:0] v);
    logic [BYTE_W-1:0] b;
    b = {{SIGN_COPY_W{v[DATA_W-1]}}, v[DATA_W-1:BYTE_W]};
    return b;
  endfunction

  assign softHit = regWrEn && (regAddr == SOFT_RESET_ADDR) && (regWrData == SOFT_RESET_CODE);
  assign statusRead = regRdEn && (regAddr == STATUS_ADDR);
  // no samples are taken in standby
  assign sampleTake = sampleStrobe && !st_r.standby;

  // thresholds are raw codes; high-byte bits above bit 2 are ignored
  assign actThr = {st_r.actThrHigh[THR_HIGH_MSB:0], st_r.actThrLow};
  assign inactThr = {st_r.inactThrHigh[THR_HIGH_MSB:0], st_r.inactThrLow};

  assign xMag = magnitude(xAccel);
  assign yMag = magnitude(yAccel);
  assign zMag = magnitude(zAccel);

  // any axis above the activity threshold
  assign actQualify = (xMag > {1'b0, actThr}) || (yMag > {1'b0, actThr})
                      || (zMag > {1'b0, actThr});
  // every axis below the inactivity threshold
  assign inactQualify = (xMag < {1'b0, inactThr}) && (yMag < {1'b0, inactThr})
                        && (zMag < {1'b0, inactThr});

  assign actTarget = wakeUpMode ? ACT_TIME_SINGLE : st_r.actTime;
  assign inactTarget = {st_r.inactTimeHigh, st_r.inactTimeLow};

  mdd_run_counter #(
    .CountW(ACT_COUNT_W)
  ) actRun (
    .clk(clk),
    .rst(rst),
    .clear(softHit),
    .strobe(sampleTake),
    .qualify(actQualify),
    .target(actTarget),
    .hit(actHit)
  );

  mdd_run_counter #(
    .CountW(INACT_COUNT_W)
  ) inactRun (
    .clk(clk),
    .rst(rst),
    .clear(softHit),
    .strobe(sampleTake),
    .qualify(inactQualify),
    .target(inactTarget),
    .hit(inactHit)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.softPulse = 1'b0;

    // read data is captured from the state before this cycle's updates
    if (regRdEn) begin
      unique case (regAddr)
        STATUS_ADDR: begin
          st_nxt.rdData = READ_ZERO;
          st_nxt.rdData[MOTION_FLAG_BIT] = st_r.motion;
          st_nxt.rdData[STILL_FLAG_BIT] = st_r.still;
        end
        Y_LOW_ADDR: st_nxt.rdData = st_r.y[BYTE_W-1:0];
        Y_HIGH_ADDR: st_nxt.rdData = highByte(st_r.y);
        Z_LOW_ADDR: st_nxt.rdData = st_r.z[BYTE_W-1:0];
        Z_HIGH_ADDR: st_nxt.rdData = highByte(st_r.z);
        TEMP_LOW_ADDR: st_nxt.rdData = st_r.temp[BYTE_W-1:0];
        TEMP_HIGH_ADDR: st_nxt.rdData = highByte(st_r.temp);
        AUX_LOW_ADDR: st_nxt.rdData = st_r.aux[BYTE_W-1:0];
        AUX_HIGH_ADDR: st_nxt.rdData = highByte(st_r.aux);
        SOFT_RESET_ADDR: st_nxt.rdData = READ_ZERO;
        ACT_THR_LOW_ADDR: st_nxt.rdData = st_r.actThrLow;
        ACT_THR_HIGH_ADDR: st_nxt.rdData = st_r.actThrHigh;
        ACT_TIME_ADDR: st_nxt.rdData = st_r.actTime;
        INACT_THR_LOW_ADDR: st_nxt.rdData = st_r.inactThrLow;
        INACT_THR_HIGH_ADDR: st_nxt.rdData = st_r.inactThrHigh;
        INACT_TIME_LOW_ADDR: st_nxt.rdData = st_r.inactTimeLow;
        INACT_TIME_HIGH_ADDR: st_nxt.rdData = st_r.inactTimeHigh;
        default: st_nxt.rdData = READ_ZERO;
      endcase
    end

    if (regWrEn) begin
      unique case (regAddr)
        ACT_THR_LOW_ADDR: st_nxt.actThrLow = regWrData;
        ACT_THR_HIGH_ADDR: st_nxt.actThrHigh = regWrData;
        ACT_TIME_ADDR: st_nxt.actTime = regWrData;
        INACT_THR_LOW_ADDR: st_nxt.inactThrLow = regWrData;
        INACT_THR_HIGH_ADDR: st_nxt.inactThrHigh = regWrData;
        INACT_TIME_LOW_ADDR: st_nxt.inactTimeLow = regWrData;
        INACT_TIME_HIGH_ADDR: st_nxt.inactTimeHigh = regWrData;
        default: ;
      endcase
    end

    if (sampleTake) begin
      st_nxt.y = yAccel;
      st_nxt.z = zAccel;
      st_nxt.temp = tempData;
      st_nxt.aux = auxData;
    end

    // a detection in the same cycle as the status read survives the clear
    st_nxt.motion = (st_r.motion && !statusRead) || actHit;
    st_nxt.still = (st_r.still && !statusRead) || inactHit;

    if (measureEnable) begin
      st_nxt.standby = 1'b0;
    end
    if (intArm) begin
      st_nxt.intOe = 1'b1;
    end

    // soft reset overrides everything, including a read in the same cycle
    if (softHit) begin
      st_nxt = RESET_STATE;
      st_nxt.intOe = 1'b0;
      st_nxt.softPulse = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign motionFlag = st_r.motion;
  assign stillFlag = st_r.still;
  assign standby = st_r.standby;
  assign softResetPulse = st_r.softPulse;
  // pin level is the motion flag; keepers outside hold it while floating
  assign intOut = st_r.motion;
  assign intOe = st_r.intOe;

  y_high_sign_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == Y_HIGH_ADDR)
    |=> regRdData == {{SIGN_COPY_W{$past(st_r.y[DATA_W-1])}}, $past(st_r.y[DATA_W-1:BYTE_W])})
    else $error("y high byte not sign extended");

  z_low_read_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == Z_LOW_ADDR) |=> regRdData == $past(st_r.z[BYTE_W-1:0]))
    else $error("z low byte read wrong");

  temp_high_read_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == TEMP_HIGH_ADDR)
    |=> regRdData[SIGN_COPY_W-1:0] == $past(st_r.temp[DATA_W-1:BYTE_W]))
    else $error("temperature high nibble read wrong");

  sample_load_a: assert property (@(posedge clk) disable iff (rst)
    (sampleTake && !softHit) |=> (st_r.aux == $past(auxData)) && (st_r.y == $past(yAccel)))
    else $error("sample words not loaded on strobe");

  soft_reset_a: assert property (@(posedge clk) disable iff (rst)
    softHit |=> standby && softResetPulse && (st_r.actThrLow == REG_RESET)
    && (st_r.inactTimeHigh == REG_RESET) && !motionFlag ##1 (!softResetPulse || $past(softHit)))
    else $error("soft reset did not clear settings and enter standby");

  int_float_a: assert property (@(posedge clk) disable iff (rst)
    softHit |=> !intOe)
    else $error("interrupt pin still driven after soft reset");

  soft_read_zero_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && regAddr == SOFT_RESET_ADDR) |=> regRdData == READ_ZERO)
    else $error("soft reset register read not zero");

  wake_single_a: assert property (@(posedge clk) disable iff (rst)
    (sampleTake && wakeUpMode && actQualify && !softHit) |=> motionFlag)
    else $error("wake-up sample did not flag activity");

  motion_set_a: assert property (@(posedge clk) disable iff (rst)
    (actHit && !softHit) |=> (motionFlag && $stable(standby)) or (motionFlag && !standby))
    else $error("activity event lost");

  status_clear_a: assert property (@(posedge clk) disable iff (rst)
    (statusRead && !actHit && !softHit && motionFlag) |=> !motionFlag ##0
    regRdData[MOTION_FLAG_BIT])
    else $error("status read did not report then clear activity");

  still_set_a: assert property (@(posedge clk) disable iff (rst)
    (inactHit && !softHit) |=> stillFlag)
    else $error("inactivity event lost");

  y_low_read_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == Y_LOW_ADDR) |=> regRdData == $past(st_r.y[BYTE_W-1:0]))
    else $error("y low byte read wrong");

  result_read_only_a: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && !sampleTake && regAddr == Y_LOW_ADDR) |=> $stable(st_r.y))
    else $error("write changed a read-only result");

  z_high_sign_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == Z_HIGH_ADDR)
    |=> regRdData == {{SIGN_COPY_W{$past(st_r.z[DATA_W-1])}}, $past(st_r.z[DATA_W-1:BYTE_W])})
    else $error("z high byte not sign extended");

  temp_low_read_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == TEMP_LOW_ADDR)
    |=> regRdData == $past(st_r.temp[BYTE_W-1:0]))
    else $error("temperature low byte read wrong");

  aux_low_read_a: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && !softHit && regAddr == AUX_LOW_ADDR)
    |=> regRdData == $past(st_r.aux[BYTE_W-1:0]))
    else $error("auxiliary low byte read wrong");

  standby_hold_a: assert property (@(posedge clk) disable iff (rst)
    (sampleStrobe && standby && !softHit)
    |=> (st_r.y == $past(st_r.y)) && (st_r.aux == $past(st_r.aux)))
    else $error("sample taken while in standby");

  soft_other_code_a: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == SOFT_RESET_ADDR && regWrData != SOFT_RESET_CODE)
    |=> !softResetPulse)
    else $error("soft reset taken for a wrong code");

  act_thr_high_a: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == ACT_THR_HIGH_ADDR)
    |=> actThr[THR_W-1:BYTE_W] == $past(regWrData[THR_HIGH_MSB:0]))
    else $error("activity threshold top bits not taken from high register");

  // a full-scale negative code exceeds every 11-bit threshold
  act_full_scale_a: assert property (@(posedge clk) disable iff (rst)
    (yAccel == 12'h800) |-> actQualify)
    else $error("full-scale sample not seen as activity");

  act_zero_a: assert property (@(posedge clk) disable iff (rst)
    ((xAccel | yAccel | zAccel) == '0) |-> !actQualify)
    else $error("zero sample seen as activity");

  still_thr_high_a: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == INACT_THR_HIGH_ADDR)
    |=> inactThr[THR_W-1:BYTE_W] == $past(regWrData[THR_HIGH_MSB:0]))
    else $error("inactivity threshold top bits not taken from high register");

  still_full_scale_a: assert property (@(posedge clk) disable iff (rst)
    (zAccel == 12'h800) |-> !inactQualify)
    else $error("full-scale sample seen as inactivity");

  still_time_high_a: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == INACT_TIME_HIGH_ADDR)
    |=> inactTarget[INACT_COUNT_W-1:BYTE_W] == $past(regWrData))
    else $error("inactivity count high byte not taken from its register");

  still_zero_time_a: assert property (@(posedge clk) disable iff (rst)
    (sampleTake && inactQualify && !softHit && inactTarget == '0) |=> stillFlag)
    else $error("zero inactivity time did not act as one");

  still_clear_a: assert property (@(posedge clk) disable iff (rst)
    (statusRead && !inactHit && !softHit && stillFlag) |=> !stillFlag ##0
    regRdData[STILL_FLAG_BIT])
    else $error("status read did not report then clear inactivity");
endmodule

// [mdd_sample_src.sv]
// converter model on the far side of the sample port.
// assumes the bench calls send from one process; each call takes two clock cycles.
`timescale 1ns/10ps
module mdd_sample_src (
  // clock
  input wire logic clk,
  // sample port
  output logic sampleStrobe,
  output logic [mdd_pkg::DATA_W-1:0] xAccel,
  output logic [mdd_pkg::DATA_W-1:0] yAccel,
  output logic [mdd_pkg::DATA_W-1:0] zAccel,
  output logic [mdd_pkg::DATA_W-1:0] tempData,
  output logic [mdd_pkg::DATA_W-1:0] auxData
);
  import mdd_pkg::*;
  initial begin
    sampleStrobe = 1'b0;
    {xAccel, yAccel, zAccel, tempData, auxData} = '0;
  end
  // one strobe per sample, words valid only with it
  task automatic send(input logic [DATA_W-1:0] x, y, z, t, a);
    @(negedge clk);
    sampleStrobe = 1'b1;
    {xAccel, yAccel, zAccel, tempData, auxData} = {x, y, z, t, a};
    @(negedge clk);
    sampleStrobe = 1'b0;
    // stale words are inverted so a late capture cannot pass by luck
    {xAccel, yAccel, zAccel, tempData, auxData} = ~{x, y, z, t, a};
  endtask
endmodule

// [mdd_regs_bench.sv]
// self-checking bench for the motion detect data register block.
// assumes a byte register port and the sample source model beside it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module mdd_regs_bench;
  import mdd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [7:0] regAddr = '0, regWrData = '0, regRdData, e, expRd;
  logic sampleStrobe, wakeUpMode = 1'b0, measureEnable = 1'b1, intArm = 1'b0;
  logic motionFlag, stillFlag, standby, softResetPulse, intOut, intOe, rdPend = 1'b0;
  logic [11:0] xAccel, yAccel, zAccel, tempData, auxData, v [4];
  logic [7:0] q [$];
  int errors = 0, checkCount = 0, cyc = 0;
  always #5 clk = ~clk;
  mdd_sample_src i_src (.clk(clk), .sampleStrobe(sampleStrobe), .xAccel(xAccel),
    .yAccel(yAccel), .zAccel(zAccel), .tempData(tempData), .auxData(auxData));
  mdd_regs i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleStrobe(sampleStrobe), .xAccel(xAccel), .yAccel(yAccel), .zAccel(zAccel),
    .tempData(tempData), .auxData(auxData), .wakeUpMode(wakeUpMode),
    .measureEnable(measureEnable), .intArm(intArm), .motionFlag(motionFlag),
    .stillFlag(stillFlag), .standby(standby), .softResetPulse(softResetPulse),
    .intOut(intOut), .intOe(intOe));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  // expected byte is noted when the read is issued
  task automatic rd(input logic [7:0] a, ex);
    @(negedge clk);
    {regAddr, regRdEn} = {a, 1'b1};
    q.push_back(ex);
    @(negedge clk);
    regRdEn = 1'b0;
  endtask
  task automatic smp(input int n, input logic [11:0] y);
    repeat (n) i_src.send(12'h000, y, 12'h000, 12'h000, 12'h000);
    @(negedge clk);
  endtask
  always @(posedge clk) rdPend <= regRdEn;
  always @(negedge clk) begin
    if (rdPend === 1'b1 && q.size() > 0) begin
      expRd = q.pop_front();
      `CHK("regRdData", expRd, regRdData)
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'hee5c));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int a = 8'h10; a <= 8'h26; a++) rd(8'(a), 8'h00);
    rd(STATUS_ADDR, 8'h00);
    $display("test reset values done");
    for (int a = 8'h20; a <= 8'h26; a++) begin
      e = 8'($urandom);
      wr(8'(a), e);
      rd(8'(a), e);
    end
    wr(Y_LOW_ADDR, 8'hff);
    rd(Y_LOW_ADDR, 8'h00);
    rd(8'h30, 8'h00);
    $display("test register access done");
    wr(ACT_THR_LOW_ADDR, 8'h0a);
    wr(ACT_THR_HIGH_ADDR, 8'hf8);
    wr(INACT_THR_LOW_ADDR, 8'h00);
    wr(INACT_THR_HIGH_ADDR, 8'h00);
    wr(ACT_TIME_ADDR, 8'h03);
    smp(1, 12'h000);
    rd(STATUS_ADDR, 8'h00);
    smp(2, 12'hff5);
    smp(1, 12'h00a);
    smp(2, 12'hff5);
    `CHK("motionFlag", 1'b0, motionFlag)
    smp(1, 12'h00b);
    `CHK("motionFlag", 1'b1, motionFlag)
    `CHK("intOut", 1'b1, intOut)
    rd(STATUS_ADDR, 8'h10);
    `CHK("motionFlag", 1'b0, motionFlag)
    wr(ACT_TIME_ADDR, 8'h00);
    smp(1, 12'h000);
    smp(1, 12'h7ff);
    rd(STATUS_ADDR, 8'h10);
    wr(ACT_TIME_ADDR, 8'h05);
    wakeUpMode = 1'b1;
    smp(1, 12'h000);
    smp(1, 12'h800);
    rd(STATUS_ADDR, 8'h10);
    wakeUpMode = 1'b0;
    $display("test activity done");
    wr(ACT_THR_LOW_ADDR, 8'hff);
    wr(ACT_THR_HIGH_ADDR, 8'h07);
    wr(INACT_THR_LOW_ADDR, 8'h32);
    wr(INACT_TIME_LOW_ADDR, 8'h03);
    wr(INACT_TIME_HIGH_ADDR, 8'h01);
    smp(1, 12'h03c);
    smp(258, 12'hfcf);
    `CHK("stillFlag", 1'b0, stillFlag)
    smp(1, 12'h031);
    `CHK("stillFlag", 1'b1, stillFlag)
    rd(STATUS_ADDR, 8'h20);
    wr(INACT_TIME_LOW_ADDR, 8'h00);
    wr(INACT_TIME_HIGH_ADDR, 8'h00);
    smp(1, 12'h032);
    smp(1, 12'h000);
    rd(STATUS_ADDR, 8'h20);
    $display("test inactivity done");
    for (int i = 0; i < 4; i++) begin
      foreach (v[j]) v[j] = (i == 0) ? 12'h800 : 12'($urandom);
      i_src.send(12'($urandom), v[0], v[1], v[2], v[3]);
      foreach (v[j]) begin
        rd(8'(Y_LOW_ADDR + 2 * j), v[j][7:0]);
        rd(8'(Y_HIGH_ADDR + 2 * j), {{4{v[j][11]}}, v[j][11:8]});
      end
    end
    wr(Y_HIGH_ADDR, 8'h00);
    rd(Y_HIGH_ADDR, {{4{v[0][11]}}, v[0][11:8]});
    $display("test results done");
    @(negedge clk);
    intArm = 1'b1;
    @(negedge clk);
    intArm = 1'b0;
    `CHK("intOe", 1'b1, intOe)
    wr(ACT_THR_LOW_ADDR, 8'h5a);
    wr(SOFT_RESET_ADDR, 8'h33);
    rd(ACT_THR_LOW_ADDR, 8'h5a);
    wr(SOFT_RESET_ADDR, SOFT_RESET_CODE);
    `CHK("softResetPulse", 1'b1, softResetPulse)
    `CHK("standby", 1'b1, standby)
    `CHK("intOe", 1'b0, intOe)
    // hold standby so the next sample must be ignored
    measureEnable = 1'b0;
    i_src.send(12'h000, 12'h123, 12'h456, 12'h789, 12'habc);
    for (int a = 8'h10; a <= 8'h26; a++) rd(8'(a), 8'h00);
    `CHK("standby", 1'b1, standby)
    $display("test soft reset done");
    repeat (2) @(negedge clk);
    finish_test();
  end
endmodule
